// file: hw/sadc_consts.vh
// constants for the successive-approximation converter control block
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH

`define SADC_ADDR_W 16
`define SADC_MODE_ADDR 16'hff80
`define SADC_CHAN_ADDR 16'hff81
`define SADC_WRES_LO_ADDR 16'hff18
`define SADC_WRES_HI_ADDR 16'hff19
`define SADC_NRES_ADDR 16'hff1a

`define SADC_MODE_RESET 8'h00
`define SADC_CHAN_RESET 8'h00
`define SADC_MODE_WMASK 8'hb9
`define SADC_CHAN_WMASK 8'h03

`define SADC_RUN_BIT 7
`define SADC_TSEL_HI 5
`define SADC_TSEL_LO 3
`define SADC_CMP_EN_BIT 0

`define SADC_RES_W 10
`define SADC_CNT_W 8

// sampling counts per timing code
`define SADC_SAMP_0 8'h0c
`define SADC_SAMP_1 8'h18
`define SADC_SAMP_2 8'h30
`define SADC_SAMP_3 8'h58
`define SADC_SAMP_4 8'h18
`define SADC_SAMP_5 8'h30
`define SADC_SAMP_6 8'h60
`define SADC_SAMP_7 8'hb0
// total conversion counts per timing code
`define SADC_CONV_0 8'h24
`define SADC_CONV_1 8'h30
`define SADC_CONV_2 8'h48
`define SADC_CONV_3 8'h70
`define SADC_CONV_4 8'h48
`define SADC_CONV_5 8'h60
`define SADC_CONV_6 8'h90
`define SADC_CONV_7 8'he0

`endif

// file: hw/sadc_result_regs.v
// result holding registers: wide and narrow conversion results
module sadc_result_regs (
    clk, // clock
    rst_n_sync, // synchronised reset, active low
    load, // load pulse at conversion end
    load_value, // finished approximation value
    wide_result, // wide result, upper six bits zero
    narrow_result // upper eight result bits
);
    input wire clk;
    input wire rst_n_sync;
    input wire load;
    input wire [9:0] load_value;
    output wire [15:0] wide_result;
    output reg [7:0] narrow_result;

    reg [9:0] wide_reg;

    // results are undefined after reset in the original part; zero is chosen here
    always @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            wide_reg <= 10'h000;
            narrow_result <= 8'h00;
        end else if (load) begin
            wide_reg <= load_value;
            narrow_result <= load_value[9:2];
        end
    end

    assign wide_result = {6'h00, wide_reg};
endmodule // sadc_result_regs

// file: hw/sadc_control.v
// control sequencer and registers of the four-input successive-approximation converter
//
// Notes on behaviour
// - four inputs; only selected pin taken over
// - sample at start, then hold until done
// - resolve msb first, then transfer result
// - wide result low ten bits, upper zero
// - narrow result gets upper eight bits
// - conversion end pulse after result load
// - reset clears mode register to zero
// - mode bit seven starts or stops conversion
// - timing code picks sample and total counts
// - mode bit zero enables the comparator
// - run starts even with comparator enable off
// - run and enable bits give three modes
// - mode register takes bit and byte writes
// - channel register selects one of four
// - mode or channel write restarts conversion
// - conversions repeat while run bit set
`include "sadc_consts.vh"

module sadc_control (
    clk, // peripheral clock, 20 MHz
    rst_b, // system reset, active low, asynchronous
    reg_addr, // register address
    reg_wr, // write strobe, one cycle
    reg_bit_wr, // write is a single-bit manipulation
    reg_bit_sel, // bit index for a single-bit write
    reg_wdata, // write data (bit write uses reg_wdata[0])
    reg_rd, // read strobe, one cycle
    reg_rdata, // read data, valid cycle after reg_rd
    cmp_above, // comparator verdict: input at or above dac tap
    chan_sel, // analog multiplexer select
    pin_analog_en, // one-hot pins taken over by the converter
    sample_en, // sample-and-hold in sample (1) or hold (0)
    comparator_on, // comparator bias enable
    dac_code, // dac tap code
    conversion_end_irq, // one-cycle pulse at conversion end
    wide_result_register, // wide result, 16 bits
    narrow_result_register // narrow result, 8 bits
);
    input wire clk;
    input wire rst_b;
    input wire [15:0] reg_addr;
    input wire reg_wr;
    input wire reg_bit_wr;
    input wire [2:0] reg_bit_sel;
    input wire [7:0] reg_wdata;
    input wire reg_rd;
    output reg [7:0] reg_rdata;
    input wire cmp_above;
    output reg [1:0] chan_sel;
    output reg [3:0] pin_analog_en;
    output reg sample_en;
    output reg comparator_on;
    output reg [9:0] dac_code;
    output reg conversion_end_irq;
    output wire [15:0] wide_result_register;
    output wire [7:0] narrow_result_register;

    localparam ST_IDLE = 2'b00;
    localparam ST_SAMPLE = 2'b01;
    localparam ST_COMPARE = 2'b10;
    localparam ST_LOAD = 2'b11;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    reg rst_meta_reg;
    reg rst_sync_reg;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [7:0] conversion_mode_control_reg;
    reg [7:0] conversion_mode_control_next;
    reg [1:0] input_channel_select_reg;
    reg [7:0] chan_byte_next;
    wire mode_hit = reg_wr && (reg_addr == `SADC_MODE_ADDR);
    wire chan_hit = reg_wr && (reg_addr == `SADC_CHAN_ADDR);

    // a bit write only touches the addressed bit; reserved bits stay zero
    always @* begin
        conversion_mode_control_next = conversion_mode_control_reg;
        chan_byte_next = {6'h00, input_channel_select_reg};
        if (reg_bit_wr) begin
            conversion_mode_control_next[reg_bit_sel] = reg_wdata[0];
            chan_byte_next[reg_bit_sel] = reg_wdata[0];
        end else begin
            conversion_mode_control_next = reg_wdata;
            chan_byte_next = reg_wdata;
        end
        conversion_mode_control_next = conversion_mode_control_next & `SADC_MODE_WMASK;
        chan_byte_next = chan_byte_next & `SADC_CHAN_WMASK;
    end

    always @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            conversion_mode_control_reg <= `SADC_MODE_RESET;
            input_channel_select_reg <= 2'b00;
        end else begin
            if (mode_hit)
                conversion_mode_control_reg <= conversion_mode_control_next;
            if (chan_hit)
                input_channel_select_reg <= chan_byte_next[1:0];
        end
    end

    wire conversion_run_bit = conversion_mode_control_reg[`SADC_RUN_BIT];
    wire comparator_enable_bit = conversion_mode_control_reg[`SADC_CMP_EN_BIT];
    wire [2:0] tsel = conversion_mode_control_reg[`SADC_TSEL_HI:`SADC_TSEL_LO];

    // ----------------------------------------------------------------
    // timing selection
    // ----------------------------------------------------------------
    reg [7:0] samp_cnt;
    reg [7:0] conv_cnt;
    always @* begin
        case (tsel)
            3'd0: begin samp_cnt = `SADC_SAMP_0; conv_cnt = `SADC_CONV_0; end
            3'd1: begin samp_cnt = `SADC_SAMP_1; conv_cnt = `SADC_CONV_1; end
            3'd2: begin samp_cnt = `SADC_SAMP_2; conv_cnt = `SADC_CONV_2; end
            3'd3: begin samp_cnt = `SADC_SAMP_3; conv_cnt = `SADC_CONV_3; end
            3'd4: begin samp_cnt = `SADC_SAMP_4; conv_cnt = `SADC_CONV_4; end
            3'd5: begin samp_cnt = `SADC_SAMP_5; conv_cnt = `SADC_CONV_5; end
            3'd6: begin samp_cnt = `SADC_SAMP_6; conv_cnt = `SADC_CONV_6; end
            default: begin samp_cnt = `SADC_SAMP_7; conv_cnt = `SADC_CONV_7; end
        endcase
    end
    // compare phase spread evenly: remainder split into ten steps, the
    // last step absorbing the leftover so the total count is exact
    wire [7:0] cmp_total = conv_cnt - samp_cnt;
    wire [7:0] step_len = cmp_total / 8'd10;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    reg [1:0] state_reg;
    reg [7:0] phase_cnt_reg;
    reg [7:0] step_cnt_reg;
    reg [3:0] bit_idx_reg;
    reg [9:0] approximation_shift_register;
    reg load_pulse_reg;
    wire restart = mode_hit || chan_hit;

    always @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= ST_IDLE;
            phase_cnt_reg <= 8'h00;
            step_cnt_reg <= 8'h00;
            bit_idx_reg <= 4'h0;
            approximation_shift_register <= 10'h000;
            load_pulse_reg <= 1'b0;
        end else begin
            load_pulse_reg <= 1'b0;
            if (restart || !conversion_run_bit) begin
                state_reg <= ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        // starts regardless of comparator enable
                        state_reg <= ST_SAMPLE;
                        phase_cnt_reg <= 8'h01;
                    end
                    ST_SAMPLE: begin
                        if (phase_cnt_reg >= samp_cnt) begin
                            state_reg <= ST_COMPARE;
                            bit_idx_reg <= 4'd9;
                            step_cnt_reg <= 8'h01;
                            approximation_shift_register <= 10'h200;
                        end
                        phase_cnt_reg <= phase_cnt_reg + 8'h01;
                    end
                    ST_COMPARE: begin
                        phase_cnt_reg <= phase_cnt_reg + 8'h01;
                        step_cnt_reg <= step_cnt_reg + 8'h01;
                        if ((bit_idx_reg != 4'd0 && step_cnt_reg >= step_len) ||
                            (bit_idx_reg == 4'd0 && phase_cnt_reg >= conv_cnt - 8'h01)) begin
                            step_cnt_reg <= 8'h01;
                            // keep or drop the trial bit, then try the next one
                            approximation_shift_register[bit_idx_reg] <= cmp_above;
                            if (bit_idx_reg == 4'd0) begin
                                state_reg <= ST_LOAD;
                            end else begin
                                approximation_shift_register[bit_idx_reg - 4'd1] <= 1'b1;
                                bit_idx_reg <= bit_idx_reg - 4'd1;
                            end
                        end
                    end
                    ST_LOAD: begin
                        load_pulse_reg <= 1'b1;
                        state_reg <= ST_SAMPLE;
                        phase_cnt_reg <= 8'h01;
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    sadc_result_regs u_results (
        .clk(clk),
        .rst_n_sync(rst_sync_reg),
        .load(load_pulse_reg),
        .load_value(approximation_shift_register),
        .wide_result(wide_result_register),
        .narrow_result(narrow_result_register)
    );

    // ----------------------------------------------------------------
    // outputs to the analog side and read port
    // ----------------------------------------------------------------
    reg irq_pend_reg;
    always @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            chan_sel <= 2'b00;
            pin_analog_en <= 4'h0;
            sample_en <= 1'b0;
            comparator_on <= 1'b0;
            dac_code <= 10'h000;
            irq_pend_reg <= 1'b0;
            conversion_end_irq <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            chan_sel <= input_channel_select_reg;
            // only the selected pin leaves port use while converting
            pin_analog_en <= conversion_run_bit ?
                (4'h1 << input_channel_select_reg) : 4'h0;
            sample_en <= (state_reg == ST_SAMPLE) && !restart;
            comparator_on <= comparator_enable_bit || conversion_run_bit;
            dac_code <= approximation_shift_register;
            // irq follows the result load by one cycle so results are visible
            irq_pend_reg <= load_pulse_reg;
            conversion_end_irq <= irq_pend_reg;
            if (reg_rd) begin
                case (reg_addr)
                    `SADC_MODE_ADDR: reg_rdata <= conversion_mode_control_reg;
                    `SADC_CHAN_ADDR: reg_rdata <= {6'h00, input_channel_select_reg};
                    `SADC_WRES_LO_ADDR: reg_rdata <= wide_result_register[7:0];
                    `SADC_WRES_HI_ADDR: reg_rdata <= wide_result_register[15:8];
                    `SADC_NRES_ADDR: reg_rdata <= narrow_result_register;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // sadc_control

// file: bench/sadc_monitor.sv
// port assertions for the converter control block
module sadc_monitor (
    input wire clk, // clock
    input wire rst_b, // reset, active low
    input wire [1:0] chan_sel, // mux select
    input wire [3:0] pin_analog_en, // pins taken over
    input wire sample_en, // sample or hold
    input wire comparator_on, // comparator bias
    input wire [9:0] dac_code, // dac tap
    input wire conversion_end_irq, // end pulse
    input wire [15:0] wide_result_register, // wide result
    input wire [7:0] narrow_result_register // narrow result
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wide_upper_zero_a: assert property (wide_result_register[15:10] == 6'h00)
        else $error("wide result upper bits not zero");
    narrow_match_a: assert property (narrow_result_register == wide_result_register[9:2])
        else $error("narrow result differs from wide result");
    result_irq_a: assert property ($changed(wide_result_register) |=> conversion_end_irq)
        else $error("result changed without end pulse");
    irq_spacing_a: assert property (conversion_end_irq |=> !conversion_end_irq [*8])
        else $error("end pulses too close");
    sample_length_a: assert property ($rose(sample_en) |-> sample_en [*8])
        else $error("sample phase too short");
    msb_first_a: assert property ($fell(sample_en) |-> ##[0:3] dac_code == 10'h200)
        else $error("first trial is not the top bit");
    conv_comparator_a: assert property (sample_en |-> comparator_on)
        else $error("sampling with comparator off");
    pin_onehot_a: assert property (pin_analog_en != 4'h0 |-> pin_analog_en == 4'h1 << chan_sel)
        else $error("analog pin does not match channel");
endmodule // sadc_monitor

// file: bench/sadc_analog_model.sv
// sample-and-hold and comparator stand-in; input level of channel c is {c, 8'h5a}
module sadc_analog_model (
    input wire clk, // clock
    input wire [1:0] chan_sel, // mux select
    input wire sample_en, // sample or hold
    input wire comparator_on, // comparator bias
    input wire [9:0] dac_code, // dac tap
    output logic cmp_above // verdict
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] held = 10'h000;
    // the held value only moves while sampling, so a late mux change cannot leak in
    always @(posedge clk) begin
        if (sample_en) begin
            held <= {chan_sel, 8'h5a};
        end
    end
    // an unbiased comparator gives noise, not a convenient answer
    assign cmp_above = comparator_on ? (held >= dac_code) : dac_code[0];
endmodule // sadc_analog_model

// file: bench/sadc_control_tb.sv
// self-checking bench for the converter control block
`include "sadc_consts.vh"
module sadc_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_bit_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [2:0] reg_bit_sel = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rv, lo;
    logic cmp_above, sample_en, comparator_on, conversion_end_irq, seen;
    logic [1:0] chan_sel;
    logic [3:0] pin_analog_en;
    logic [9:0] dac_code;
    logic [15:0] wide_result_register;
    logic [7:0] narrow_result_register;
    int errors = 0, n_compared = 0, cycles = 0, n, k;
    int samp_t [8] = '{`SADC_SAMP_0, `SADC_SAMP_1, `SADC_SAMP_2, `SADC_SAMP_3,
        `SADC_SAMP_4, `SADC_SAMP_5, `SADC_SAMP_6, `SADC_SAMP_7};
    int conv_t [8] = '{`SADC_CONV_0, `SADC_CONV_1, `SADC_CONV_2, `SADC_CONV_3,
        `SADC_CONV_4, `SADC_CONV_5, `SADC_CONV_6, `SADC_CONV_7};
    always #25 clk = ~clk;
    sadc_control DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_bit_wr(reg_bit_wr), .reg_bit_sel(reg_bit_sel), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_above(cmp_above), .chan_sel(chan_sel),
        .pin_analog_en(pin_analog_en), .sample_en(sample_en), .comparator_on(comparator_on),
        .dac_code(dac_code), .conversion_end_irq(conversion_end_irq),
        .wide_result_register(wide_result_register),
        .narrow_result_register(narrow_result_register));
    sadc_analog_model mdl (.clk(clk), .chan_sel(chan_sel), .sample_en(sample_en),
        .comparator_on(comparator_on), .dac_code(dac_code), .cmp_above(cmp_above));
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            print_verdict();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 1'b0,
        input logic [2:0] s = 3'h0);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_bit_wr = b;
        reg_bit_sel = s;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_bit_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    // count negedges until the end pulse; k stops at the bound on a hang
    task automatic wait_irq;
        k = 0;
        while (conversion_end_irq !== 1'b1 && k < 400) begin
            @(negedge clk);
            k = k + 1;
        end
    endtask
    // mode writes while running are kept out of the sample phase
    task automatic wait_hold;
        while (sample_en !== 1'b1) @(negedge clk);
        while (sample_en !== 1'b0) @(negedge clk);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        rd(`SADC_MODE_ADDR, rv); check(rv, 8'h00);
        rd(`SADC_CHAN_ADDR, rv); check(rv, 8'h00);
        rd(16'hff00, rv); check(rv, 8'h00);
        wr(`SADC_MODE_ADDR, 8'h01, 1'b1);
        rd(`SADC_MODE_ADDR, rv); check(rv, 8'h01);
        check(comparator_on, 1'b1);
        check({sample_en, pin_analog_en}, 5'h00);
        repeat (24) @(negedge clk); // comparator settling time
        for (int c = 0; c < 8; c++) begin
            wr(`SADC_CHAN_ADDR, {6'h00, c[1:0]});
            wr(`SADC_MODE_ADDR, {2'b00, c[2:0], 3'b001});
            repeat (2) @(negedge clk);
            wr(`SADC_MODE_ADDR, {2'b10, c[2:0], 3'b001});
            while (sample_en !== 1'b1) @(negedge clk);
            n = 0;
            while (sample_en === 1'b1 && n < 300) begin
                @(negedge clk);
                n = n + 1;
            end
            check(n[15:0], samp_t[c][15:0]);
            wait_irq();
            check(n + k >= conv_t[c] && n + k <= conv_t[c] + 4, 1'b1);
            rd(`SADC_WRES_LO_ADDR, lo);
            rd(`SADC_WRES_HI_ADDR, rv);
            check({rv, lo}, {6'h00, c[1:0], 8'h5a});
            rd(`SADC_NRES_ADDR, rv); check(rv, {c[1:0], 6'h16});
            check(pin_analog_en, 4'h1 << c[1:0]);
            wait_hold();
            wr(`SADC_MODE_ADDR, {2'b00, c[2:0], 3'b001});
        end
        // stop first, then change the timing code, then let two cycles pass before run
        wr(`SADC_MODE_ADDR, 8'h21);
        repeat (2) @(negedge clk);
        wr(`SADC_MODE_ADDR, 8'ha1);
        wait_hold();
        repeat (5) @(negedge clk);
        wr(`SADC_CHAN_ADDR, 8'hfd);
        n = 0;
        seen = 1'b0;
        while (sample_en !== 1'b1 && n < 20) begin
            seen = seen | conversion_end_irq;
            @(negedge clk);
            n = n + 1;
        end
        check({seen, n < 6}, 2'b01);
        wait_irq();
        check(wide_result_register, 16'h015a);
        rd(`SADC_CHAN_ADDR, rv); check(rv, 8'h01);
        wait_hold();
        // stop keeps the timing code; the reserved ones must not stick
        wr(`SADC_MODE_ADDR, 8'h66);
        rd(`SADC_MODE_ADDR, rv); check(rv, 8'h20);
        seen = 1'b0;
        repeat (300) begin
            @(negedge clk);
            seen = seen | conversion_end_irq | sample_en | comparator_on;
        end
        check(seen, 1'b0);
        // run set by a single-bit write with the comparator enable bit still clear; run turns the comparator on, result is loaded but not checked
        wr(`SADC_MODE_ADDR, 8'h01, 1'b1, 3'd7);
        wait_irq();
        check(conversion_end_irq, 1'b1);
        rd(`SADC_MODE_ADDR, rv); check(rv, 8'ha0);
        print_verdict();
    end
endmodule // sadc_control_tb
bind sadc_control sadc_monitor u_mon (.clk(clk), .rst_b(rst_b), .chan_sel(chan_sel),
    .pin_analog_en(pin_analog_en), .sample_en(sample_en), .comparator_on(comparator_on),
    .dac_code(dac_code), .conversion_end_irq(conversion_end_irq),
    .wide_result_register(wide_result_register),
    .narrow_result_register(narrow_result_register));
